// *** inc/mnp_pkg.sv ***
// Purpose: shared constants for the motion network pin interface block
// Assumes: 50 MHz ref_clk, APB slave with 32-bit data and byte addresses
// Notes:   offsets are byte addresses, one aligned word per register
package mnp_pkg;

   // bus geometry
   localparam int unsigned MNP_ADDR_W      = 8;
   localparam int unsigned MNP_DATA_W      = 32;

   // register byte offsets
   localparam logic [7:0]  MNP_OFS_CTRL    = 8'h00;
   localparam logic [7:0]  MNP_OFS_AX0_CMD = 8'h04;
   localparam logic [7:0]  MNP_OFS_AX1_CMD = 8'h08;
   localparam logic [7:0]  MNP_OFS_EVENT   = 8'h0C;
   localparam logic [7:0]  MNP_OFS_STATUS  = 8'h10;
   localparam logic [7:0]  MNP_OFS_AX0_POS = 8'h14;
   localparam logic [7:0]  MNP_OFS_AX1_POS = 8'h18;
   localparam logic [7:0]  MNP_OFS_TX_DATA = 8'h1C;

   // control register fields
   localparam int unsigned MNP_CTRL_RUN_LSB  = 0;
   localparam int unsigned MNP_CTRL_DIR_LSB  = 2;
   localparam int unsigned MNP_CTRL_DINV_LSB = 4;
   localparam int unsigned MNP_CTRL_OUTPUT_DATA_NOT_ARRIVED     = 8;
   localparam int unsigned MNP_CTRL_LINK     = 9;
   localparam int unsigned MNP_CTRL_PING     = 10;
   localparam int unsigned MNP_CTRL_CYCLE_TIME_INDICATOR_N     = 11;
   localparam int unsigned MNP_CTRL_HWERR    = 12;
   localparam logic [12:0] MNP_CTRL_RST      = 13'h0000;

   // per-axis command register fields
   localparam int unsigned MNP_GP_W          = 4;
   localparam int unsigned MNP_HALF_W        = 16;
   localparam int unsigned MNP_CMD_GP_LSB    = 0;
   localparam int unsigned MNP_CMD_INV_LSB   = 4;
   localparam int unsigned MNP_CMD_HALF_LSB  = 8;
   localparam logic [23:0] MNP_CMD_RST       = 24'h010000;

   // event register fields (write one to fire)
   localparam int unsigned MNP_EVT_MAIL      = 0;
   localparam int unsigned MNP_EVT_LINK      = 1;

   // status register fields
   localparam int unsigned MNP_ST_DIM_LSB    = 0;
   localparam int unsigned MNP_ST_SENS_LSB   = 8;
   localparam int unsigned MNP_ST_ALL_STOP_N    = 14;
   localparam int unsigned MNP_ST_SYNC       = 15;
   localparam int unsigned MNP_ST_TXBUSY     = 16;
   localparam int unsigned MNP_ST_RXACT      = 17;
   localparam int unsigned MNP_ST_MOVE_LSB   = 18;

   // timing
   localparam int unsigned MNP_CLK_HZ        = 50_000_000;
   localparam int unsigned MNP_CARE_MS       = 50;
   localparam int unsigned MNP_CARE_CYCLES   = MNP_CARE_MS * (MNP_CLK_HZ / 1000);
   localparam int unsigned MNP_TX_BIT_NS     = 160;
   localparam int unsigned MNP_TX_BIT_CYCLES = (MNP_TX_BIT_NS * (MNP_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned MNP_TX_BITS       = 8;

   // transmitter states
   typedef enum logic [1:0] {
      MNP_TX_IDLE  = 2'b01,
      MNP_TX_SHIFT = 2'b10
   } mnp_tx_state_t;

endpackage

// *** rtl/mnp_pin_if.sv ***
// Purpose: pin-level logic of a two-axis motion controller on a cyclic network
// Assumes: one 50 MHz clock, all pin inputs asynchronous, APB register access
// Notes:   motion profiles are reduced to a fixed-rate step generator
//
// Summary of operation
// - direction output low means clockwise unless that output is inverted
// - step pulse output stays low whenever its axis is stopped
// - general-purpose output goes high when its command bit is 1, no inversion; the code inverts each bit whose invert field bit is set
// - no-arrival output high while the not-arrived condition holds, low otherwise
// - falling edge of the sync trigger input marks the sync instant
// - ping event drives the active-low ping indicator low
// - cycle-time event drives the active-low cycle indicator low
// - all-stop is a level: active for as long as its input is low
// - mail-care indicator pulses low about 50 ms per event and after reset
// - link-care indicator pulses low about 50 ms per event and after reset
// - hardware error may hold both care indicators low
// - monitor output low while a stable link with another node exists
// - packets leave serially; transmit enable high exactly while sending
// - low on a general-purpose input reads as 1 in its monitor bit
// - position counts on each rising edge of the axis count clock
// - count direction low adds one, high subtracts one
// - low on origin or limit sensor input means that sensor is active
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module mnp_pin_if
   import mnp_pkg::*;
#(
   parameter int unsigned CARE_CYCLES   = mnp_pkg::MNP_CARE_CYCLES,
   parameter int unsigned TX_BIT_CYCLES = mnp_pkg::MNP_TX_BIT_CYCLES
) (
   input  wire logic                               ref_clk,
   input  wire logic                               rst,
   input  wire logic                               clk_en,
   // apb slave
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [mnp_pkg::MNP_ADDR_W-1:0]     paddr,
   input  wire logic [mnp_pkg::MNP_DATA_W-1:0]     pwdata,
   output logic      [mnp_pkg::MNP_DATA_W-1:0]     prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   // axis pins
   output logic                                    axis0_direction_out,
   output logic                                    axis1_direction_out,
   output logic                                    axis0_step_pulse_out,
   output logic                                    axis1_step_pulse_out,
   output logic      [mnp_pkg::MNP_GP_W-1:0]       axis0_gp_output,
   output logic      [mnp_pkg::MNP_GP_W-1:0]       axis1_gp_output,
   input  wire logic [mnp_pkg::MNP_GP_W-1:0]       axis0_gp_input_n,
   input  wire logic [mnp_pkg::MNP_GP_W-1:0]       axis1_gp_input_n,
   input  wire logic                               axis0_origin_n,
   input  wire logic                               axis0_plus_limit_n,
   input  wire logic                               axis0_minus_limit_n,
   input  wire logic                               axis1_origin_n,
   input  wire logic                               axis1_plus_limit_n,
   input  wire logic                               axis1_minus_limit_n,
   input  wire logic                               axis0_count_clock,
   input  wire logic                               axis1_count_clock,
   input  wire logic                               axis0_count_direction,
   input  wire logic                               axis1_count_direction,
   // system pins
   input  wire logic                               sync_trigger_n,
   input  wire logic                               all_stop_n,
   input  wire logic                               core_clock_in,
   // network status indicators
   output logic                                    output_data_not_arrived,
   output logic                                    ping_indicator_n,
   output logic                                    cycle_time_indicator_n,
   output logic                                    mail_care_indicator_n,
   output logic                                    link_care_indicator_n,
   output logic                                    link_monitor_n,
   // network line
   output logic                                    net_tx_data,
   output logic                                    net_tx_enable,
   input  wire logic                               net_rx_data
);

   localparam int unsigned CARE_W  = $clog2(CARE_CYCLES + 1);
   localparam int unsigned BIT_W   = $clog2(TX_BIT_CYCLES + 1);
   localparam int unsigned NBIT_W  = $clog2(MNP_TX_BITS + 1);
   localparam int unsigned SYNC_W  = 2 * MNP_GP_W + 6 + 4 + 3;

   // input synchronisers
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;

   // gather every pin input that crosses into ref_clk
   assign raw_in = {axis1_gp_input_n, axis0_gp_input_n,
                    axis1_origin_n, axis1_plus_limit_n, axis1_minus_limit_n,
                    axis0_origin_n, axis0_plus_limit_n, axis0_minus_limit_n,
                    axis1_count_clock, axis1_count_direction,
                    axis0_count_clock, axis0_count_direction,
                    sync_trigger_n, all_stop_n, net_rx_data};

   // two-stage synchroniser, first stage feeds only the second
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= '1;
         sync2_r <= '1;
      end else if (clk_en) begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end

   logic [MNP_GP_W-1:0] gp_in_n_s [2];
   logic [2:0]          sens_n_s  [2];
   logic [1:0]          cnt_clk_s;
   logic [1:0]          cnt_dir_s;
   logic                sync_trig_n_s;
   logic                all_stop_n_s;
   logic                rx_s;

   // split the synchronised vector back into named signals
   assign gp_in_n_s[1]  = sync2_r[SYNC_W-1 -: MNP_GP_W];
   assign gp_in_n_s[0]  = sync2_r[SYNC_W-1-MNP_GP_W -: MNP_GP_W];
   assign sens_n_s[1]   = sync2_r[12:10];
   assign sens_n_s[0]   = sync2_r[9:7];
   assign cnt_clk_s[1]  = sync2_r[6];
   assign cnt_dir_s[1]  = sync2_r[5];
   assign cnt_clk_s[0]  = sync2_r[4];
   assign cnt_dir_s[0]  = sync2_r[3];
   assign sync_trig_n_s = sync2_r[2];
   assign all_stop_n_s  = sync2_r[1];
   assign rx_s          = sync2_r[0];

   // active-high views of the low-true inputs
   logic all_stop_act;
   logic rx_act;
   assign all_stop_act = ~all_stop_n_s;
   assign rx_act       = ~rx_s;

   // apb decode
   logic addr_hit;
   logic wr_en;
   logic rd_setup;
   logic [MNP_DATA_W-1:0] rd_mux;

   // legal word offsets only; anything else answers with an error
   always_comb begin
      case (paddr)
         MNP_OFS_CTRL, MNP_OFS_AX0_CMD, MNP_OFS_AX1_CMD, MNP_OFS_EVENT,
         MNP_OFS_STATUS, MNP_OFS_AX0_POS, MNP_OFS_AX1_POS, MNP_OFS_TX_DATA: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // one-cycle access phase, stalled only while the block is frozen
   assign pready   = clk_en;
   assign pslverr  = psel & penable & clk_en & ~addr_hit;
   assign wr_en    = psel & penable & pwrite & clk_en & addr_hit;
   assign rd_setup = psel & ~penable & ~pwrite & clk_en;

   // software registers
   logic [12:0] ctrl_r;
   logic [23:0] cmd_r [2];
   logic [1:0]  evt_pulse;
   logic        sync_flag_r;
   logic        sync_prev_r;
   logic        sync_fall;

   // control register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= MNP_CTRL_RST;
      end else if (clk_en && wr_en && paddr == MNP_OFS_CTRL) begin
         ctrl_r <= pwdata[12:0];
      end
   end

   // per-axis command registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_r[0] <= MNP_CMD_RST;
         cmd_r[1] <= MNP_CMD_RST;
      end else if (clk_en && wr_en) begin
         if (paddr == MNP_OFS_AX0_CMD) begin
            cmd_r[0] <= pwdata[23:0];
         end
         if (paddr == MNP_OFS_AX1_CMD) begin
            cmd_r[1] <= pwdata[23:0];
         end
      end
   end

   // write-one event strobes for the care indicators
   assign evt_pulse = (wr_en && paddr == MNP_OFS_EVENT) ?
                      {pwdata[MNP_EVT_LINK], pwdata[MNP_EVT_MAIL]} : 2'b00;

   // sync trigger falling edge, sticky flag; a new edge beats the clear
   assign sync_fall = sync_prev_r & ~sync_trig_n_s;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync_prev_r <= 1'b1;
         sync_flag_r <= 1'b0;
      end else if (clk_en) begin
         sync_prev_r <= sync_trig_n_s;
         if (sync_fall) begin
            sync_flag_r <= 1'b1;
         end else if (wr_en && paddr == MNP_OFS_STATUS && pwdata[MNP_ST_SYNC]) begin
            sync_flag_r <= 1'b0;
         end
      end
   end

   // per-axis logic
   logic [31:0]         pos_r     [2];
   logic                step_r    [2];
   logic                dir_out_r [2];
   logic [MNP_GP_W-1:0] gp_out_r  [2];
   logic [1:0]          moving;

   genvar ax;
   generate
      for (ax = 0; ax < 2; ax++) begin : g_axis
         logic                  cnt_prev_r;
         logic [MNP_HALF_W-1:0] half_cnt_r;
         logic                  dir_bit;
         logic                  limit_hit;
         logic [MNP_HALF_W-1:0] half_per;

         assign dir_bit  = ctrl_r[MNP_CTRL_DIR_LSB + ax];
         assign half_per = cmd_r[ax][MNP_CMD_HALF_LSB +: MNP_HALF_W];
         // plus limit blocks clockwise, minus limit blocks the other way
         assign limit_hit = dir_bit ? ~sens_n_s[ax][0] : ~sens_n_s[ax][1];
         assign moving[ax] = ctrl_r[MNP_CTRL_RUN_LSB + ax] & ~all_stop_act & ~limit_hit;

         // position counter on rising count clock
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               cnt_prev_r <= 1'b1;    // matches synchroniser reset, no false edge
               pos_r[ax]  <= 32'h0000_0000;
            end else if (clk_en) begin
               cnt_prev_r <= cnt_clk_s[ax];
               if (wr_en && paddr == (ax == 0 ? MNP_OFS_AX0_POS : MNP_OFS_AX1_POS)) begin
                  pos_r[ax] <= pwdata;
               end else if (cnt_clk_s[ax] && !cnt_prev_r) begin
                  pos_r[ax] <= cnt_dir_s[ax] ? pos_r[ax] - 32'h0000_0001
                                             : pos_r[ax] + 32'h0000_0001;
               end
            end
         end

         // step generator, square wave of two half periods
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               half_cnt_r <= '0;
               step_r[ax] <= 1'b0;
            end else if (clk_en) begin
               if (!moving[ax]) begin
                  half_cnt_r <= '0;
                  step_r[ax] <= 1'b0;
               end else if (half_cnt_r >= half_per) begin
                  half_cnt_r <= '0;
                  step_r[ax] <= ~step_r[ax];
               end else begin
                  half_cnt_r <= half_cnt_r + 1'b1;
               end
            end
         end

         // direction and general-purpose outputs from flip-flops
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               dir_out_r[ax] <= 1'b0;
               gp_out_r[ax]  <= '0;
            end else if (clk_en) begin
               dir_out_r[ax] <= dir_bit ^ ctrl_r[MNP_CTRL_DINV_LSB + ax];
               gp_out_r[ax]  <= cmd_r[ax][MNP_CMD_GP_LSB +: MNP_GP_W]
                              ^ cmd_r[ax][MNP_CMD_INV_LSB +: MNP_GP_W];
            end
         end
      end
   endgenerate

   assign axis0_direction_out  = dir_out_r[0];
   assign axis1_direction_out  = dir_out_r[1];
   assign axis0_step_pulse_out = step_r[0];
   assign axis1_step_pulse_out = step_r[1];
   assign axis0_gp_output      = gp_out_r[0];
   assign axis1_gp_output      = gp_out_r[1];

   // network indicators
   logic [CARE_W-1:0] care_cnt_r [2];
   logic              care_n_r   [2];
   logic              output_data_not_arrived_r;
   logic              ping_n_r;
   logic              cycle_time_indicator_n_n_r;
   logic              mon_n_r;

   // care pulse timers, loaded at reset so each pulses once after release
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         care_cnt_r[0] <= CARE_W'(CARE_CYCLES);
         care_cnt_r[1] <= CARE_W'(CARE_CYCLES);
      end else if (clk_en) begin
         for (int i = 0; i < 2; i++) begin
            if (evt_pulse[i]) begin
               care_cnt_r[i] <= CARE_W'(CARE_CYCLES);
            end else if (care_cnt_r[i] != '0) begin
               care_cnt_r[i] <= care_cnt_r[i] - 1'b1;
            end
         end
      end
   end

   // indicator pins, error forces both care lamps on
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         care_n_r[0] <= 1'b0;
         care_n_r[1] <= 1'b0;
         output_data_not_arrived_r      <= 1'b0;
         ping_n_r    <= 1'b1;
         cycle_time_indicator_n_n_r    <= 1'b1;
         mon_n_r     <= 1'b1;
      end else if (clk_en) begin
         care_n_r[0] <= ~((care_cnt_r[0] != '0) | ctrl_r[MNP_CTRL_HWERR]);
         care_n_r[1] <= ~((care_cnt_r[1] != '0) | ctrl_r[MNP_CTRL_HWERR]);
         output_data_not_arrived_r      <= ctrl_r[MNP_CTRL_OUTPUT_DATA_NOT_ARRIVED];
         ping_n_r    <= ~ctrl_r[MNP_CTRL_PING];
         cycle_time_indicator_n_n_r    <= ~ctrl_r[MNP_CTRL_CYCLE_TIME_INDICATOR_N];
         mon_n_r     <= ~ctrl_r[MNP_CTRL_LINK];
      end
   end

   assign mail_care_indicator_n   = care_n_r[0];
   assign link_care_indicator_n   = care_n_r[1];
   assign output_data_not_arrived = output_data_not_arrived_r;
   assign ping_indicator_n        = ping_n_r;
   assign cycle_time_indicator_n  = cycle_time_indicator_n_n_r;
   assign link_monitor_n          = mon_n_r;

   // serial transmitter
   mnp_tx_state_t            tx_state_r;
   logic [MNP_TX_BITS-1:0]   tx_shift_r;
   logic [BIT_W-1:0]         tx_bit_cnt_r;
   logic [NBIT_W-1:0]        tx_nbits_r;
   logic                     tx_busy;

   assign tx_busy = (tx_state_r == MNP_TX_SHIFT);

   // lsb-first shifter; a write while busy is dropped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_state_r   <= MNP_TX_IDLE;
         tx_shift_r   <= '0;
         tx_bit_cnt_r <= '0;
         tx_nbits_r   <= '0;
      end else if (clk_en) begin
         case (tx_state_r)
            MNP_TX_IDLE: begin
               if (wr_en && paddr == MNP_OFS_TX_DATA) begin
                  tx_shift_r   <= pwdata[MNP_TX_BITS-1:0];
                  tx_bit_cnt_r <= '0;
                  tx_nbits_r   <= '0;
                  tx_state_r   <= MNP_TX_SHIFT;
               end
            end
            MNP_TX_SHIFT: begin
               if (tx_bit_cnt_r == BIT_W'(TX_BIT_CYCLES - 1)) begin
                  tx_bit_cnt_r <= '0;
                  tx_shift_r   <= {1'b0, tx_shift_r[MNP_TX_BITS-1:1]};
                  if (tx_nbits_r == NBIT_W'(MNP_TX_BITS - 1)) begin
                     tx_state_r <= MNP_TX_IDLE;
                  end else begin
                     tx_nbits_r <= tx_nbits_r + 1'b1;
                  end
               end else begin
                  tx_bit_cnt_r <= tx_bit_cnt_r + 1'b1;
               end
            end
            default: begin
               tx_state_r <= MNP_TX_IDLE;
            end
         endcase
      end
   end

   // line pins held in flip-flops, enable covers the whole packet
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         net_tx_data   <= 1'b0;
         net_tx_enable <= 1'b0;
      end else if (clk_en) begin
         net_tx_data   <= tx_busy ? tx_shift_r[0] : 1'b0;
         net_tx_enable <= tx_busy;
      end
   end

   // read path
   always_comb begin
      rd_mux = '0;
      case (paddr)
         MNP_OFS_CTRL:    rd_mux[12:0] = ctrl_r;
         MNP_OFS_AX0_CMD: rd_mux[23:0] = cmd_r[0];
         MNP_OFS_AX1_CMD: rd_mux[23:0] = cmd_r[1];
         MNP_OFS_STATUS: begin
            rd_mux[MNP_ST_DIM_LSB +: MNP_GP_W]            = ~gp_in_n_s[0];
            rd_mux[MNP_ST_DIM_LSB + MNP_GP_W +: MNP_GP_W] = ~gp_in_n_s[1];
            rd_mux[MNP_ST_SENS_LSB +: 3]                  = ~sens_n_s[0];
            rd_mux[MNP_ST_SENS_LSB + 3 +: 3]              = ~sens_n_s[1];
            rd_mux[MNP_ST_ALL_STOP_N]                        = all_stop_act;
            rd_mux[MNP_ST_SYNC]                           = sync_flag_r;
            rd_mux[MNP_ST_TXBUSY]                         = tx_busy;
            rd_mux[MNP_ST_RXACT]                          = rx_act;
            rd_mux[MNP_ST_MOVE_LSB +: 2]                  = moving;
         end
         MNP_OFS_AX0_POS: rd_mux = pos_r[0];
         MNP_OFS_AX1_POS: rd_mux = pos_r[1];
         default:         rd_mux = '0;
      endcase
   end

   // read data captured in the setup cycle, held for the access phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= '0;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

endmodule

// *** verif/mnp_pin_if_asserts.sv ***
// Purpose: port assertions for mnp_pin_if
// Assumes: clk_en held high
// Notes:   ctrl_r mirrors ctrl writes
`timescale 1ns/100ps
module mnp_pin_if_asserts
   import mnp_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        axis0_direction_out,
   input wire logic        axis0_step_pulse_out,
   input wire logic        output_data_not_arrived,
   input wire logic        ping_indicator_n,
   input wire logic        cycle_time_indicator_n,
   input wire logic        mail_care_indicator_n,
   input wire logic        link_monitor_n,
   input wire logic        net_tx_enable
);
   logic [12:0] ctrl_r, ctrl_dly_r;
   logic        wr;
   assign wr = psel && penable && pwrite;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ctrl as written, then as the pins show it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r     <= '0;
         ctrl_dly_r <= '0;
      end else begin
         if (wr && paddr == MNP_OFS_CTRL) ctrl_r <= pwdata[12:0];
         ctrl_dly_r <= ctrl_r;
      end
   end
   sequence s_tx_go;
      wr && paddr == MNP_OFS_TX_DATA && !net_tx_enable;
   endsequence
   a_output_data_not_arrived_level: assert property (output_data_not_arrived == ctrl_dly_r[8]) else $error("output_data_not_arrived");
   a_mon_low: assert property (link_monitor_n == !ctrl_dly_r[9]) else $error("monitor");
   a_ping_low: assert property (ping_indicator_n == !ctrl_dly_r[10]) else $error("ping");
   a_cycle_time_indicator_n_low: assert property (cycle_time_indicator_n == !ctrl_dly_r[11]) else $error("cycle");
   a_dir_invert: assert property (axis0_direction_out == (ctrl_dly_r[2] ^ ctrl_dly_r[4])) else $error("dir");
   a_hwerr_care: assert property (ctrl_dly_r[12] |-> !mail_care_indicator_n) else $error("care");
   a_step_stop: assert property (!ctrl_dly_r[0] && !$past(ctrl_dly_r[0]) |-> !axis0_step_pulse_out) else $error("step");
   a_care_reset: assert property ($fell(rst) |-> !mail_care_indicator_n [*8]) else $error("care short");
   a_tx_start: assert property (s_tx_go |-> ##2 net_tx_enable) else $error("tx late");
endmodule
bind mnp_pin_if mnp_pin_if_asserts u_chk (.*);

// *** verif/mnp_far_side.sv ***
// Purpose: line driver and receiver model
// Assumes: one tx bit per cycle
// Notes:   loops tx back, active low
`timescale 1ns/100ps
module mnp_far_side (
   input  wire logic       ref_clk,
   input  wire logic       net_tx_data,
   input  wire logic       net_tx_enable,
   output logic            net_rx_data,
   output logic [7:0]      rx_byte_r
);
   // idle high, inverted data while driven
   assign net_rx_data = !(net_tx_enable && net_tx_data);
   // lsb first while enabled
   always_ff @(posedge ref_clk)
      if (net_tx_enable) rx_byte_r <= {net_tx_data, rx_byte_r[7:1]};
endmodule

// *** verif/test_mnp_pin_if.sv ***
// Purpose: directed tests of mnp_pin_if
// Assumes: short care and bit timing
// Notes:   far side loops tx back
`timescale 1ns/100ps
module test_mnp_pin_if;
   import mnp_pkg::*;
   logic ref_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, core_clock_in, err;
   logic [7:0] paddr, rx_byte;
   logic [31:0] pwdata, prdata, rd;
   logic axis0_direction_out, axis1_direction_out, axis0_step_pulse_out, axis1_step_pulse_out;
   logic [3:0] axis0_gp_output, axis1_gp_output, axis0_gp_input_n, axis1_gp_input_n;
   logic axis0_origin_n, axis0_plus_limit_n, axis0_minus_limit_n, axis1_origin_n, axis1_plus_limit_n;
   logic axis1_minus_limit_n, axis0_count_clock, axis1_count_clock, axis0_count_direction;
   logic axis1_count_direction, sync_trigger_n, all_stop_n, output_data_not_arrived, ping_indicator_n;
   logic cycle_time_indicator_n, mail_care_indicator_n, link_care_indicator_n, link_monitor_n;
   logic net_tx_data, net_tx_enable, net_rx_data;
   int fail_count, num_checks, hi;
   assign axis1_count_clock = axis0_count_clock;
   assign axis1_count_direction = !axis0_count_direction;
   mnp_pin_if #(.CARE_CYCLES(20), .TX_BIT_CYCLES(1)) dut (.*);
   mnp_far_side far (.*, .rx_byte_r(rx_byte));
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      core_clock_in = 0;
      forever #10.4 core_clock_in = ~core_clock_in;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic steps();
      hi = 0;
      repeat (12) @(posedge ref_clk) hi += axis0_step_pulse_out;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #50us;
      fail_count++;
      complete_run();
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, clk_en, rst} = '1;
      {psel, penable, pwrite} = '0;
      {axis0_gp_input_n, axis1_gp_input_n, axis0_origin_n, axis0_plus_limit_n, axis0_minus_limit_n} = '1;
      {axis1_origin_n, axis1_plus_limit_n, axis1_minus_limit_n, sync_trigger_n, all_stop_n} = '1;
      {axis0_count_clock, axis0_count_direction} = '0;
      repeat (6) @(posedge ref_clk);
      rst <= 0;
      tick(2);
      chk("care low", 0, {mail_care_indicator_n, link_care_indicator_n});
      tick(25);
      chk("care end", 3, {mail_care_indicator_n, link_care_indicator_n});
      bus(1, MNP_OFS_EVENT, 32'h3);
      tick(2);
      chk("care event", 0, {mail_care_indicator_n, link_care_indicator_n});
      bus(1, MNP_OFS_CTRL, 32'h0F04);
      tick(3);
      chk("pins set", 5'h18, {axis0_direction_out, output_data_not_arrived, link_monitor_n, ping_indicator_n,
          cycle_time_indicator_n});
      bus(1, MNP_OFS_CTRL, 32'h1014);
      tick(3);
      chk("pins clear", 5'h07, {axis0_direction_out, output_data_not_arrived, link_monitor_n, ping_indicator_n,
          cycle_time_indicator_n});
      chk("hw error", 0, {mail_care_indicator_n, link_care_indicator_n});
      bus(1, MNP_OFS_AX1_CMD, 32'h0001_0005);
      tick(2);
      chk("gp out", 5, axis1_gp_output);
      bus(1, MNP_OFS_AX1_CMD, 32'h0001_0055);
      tick(2);
      chk("gp invert", 0, axis1_gp_output);
      @(posedge ref_clk);
      {axis0_gp_input_n, axis1_gp_input_n, axis0_origin_n, axis1_minus_limit_n} <= 10'h28C;
      {all_stop_n, sync_trigger_n} <= 2'b00;
      tick(4);
      bus(0, MNP_OFS_STATUS, 0);
      chk("status", 16'hCCC5, rd[15:0]);
      all_stop_n <= 1;
      bus(1, MNP_OFS_STATUS, 32'h8000);
      tick(4);
      bus(0, MNP_OFS_STATUS, 0);
      chk("status held", 16'h0CC5, rd[15:0]);
      {axis0_gp_input_n, axis1_gp_input_n, axis0_origin_n, axis1_minus_limit_n, sync_trigger_n} <= '1;
      bus(1, MNP_OFS_AX0_POS, 32'd100);
      for (int i = 0; i < 4; i++) begin
         axis0_count_direction <= (i == 3);
         repeat (4) @(posedge ref_clk);
         axis0_count_clock <= 1;
         repeat (4) @(posedge ref_clk);
         axis0_count_clock <= 0;
      end
      tick(5);
      bus(0, MNP_OFS_AX0_POS, 0);
      chk("pos up", 32'd102, rd);
      bus(0, MNP_OFS_AX1_POS, 0);
      chk("pos down", 32'hFFFF_FFFE, rd);
      bus(1, MNP_OFS_AX0_CMD, 32'h0000_0200);
      bus(1, MNP_OFS_CTRL, 32'h1);
      steps();
      chk("moving", 1, hi > 0);
      all_stop_n <= 0;
      tick(5);
      steps();
      chk("stopped", 0, hi);
      bus(1, MNP_OFS_TX_DATA, 32'hA5);
      tick(20);
      chk("tx byte", 9'h0A5, {net_tx_enable, rx_byte});
      bus(0, 8'h40, 0);
      chk("slverr", 1, err);
      chk("bad read", 0, rd);
      complete_run();
   end
endmodule
